// File: hdl/dmactl_pkg.sv
// dmactl_pkg: offsets, field positions and reset values of the DMA control block
// assumes an 8-bit internal I/O space with 8-bit data
package dmactl_pkg;
  // I/O offsets of the block's registers
  localparam logic [7:0] OFF_SRC0_LOW   = 8'h20;
  localparam logic [7:0] OFF_SRC0_HIGH  = 8'h21;
  localparam logic [7:0] OFF_SRC0_BANK  = 8'h22;
  localparam logic [7:0] OFF_BCNT0_LOW  = 8'h26;
  localparam logic [7:0] OFF_BCNT0_HIGH = 8'h27;
  localparam logic [7:0] OFF_BCNT1_LOW  = 8'h2E;
  localparam logic [7:0] OFF_BCNT1_HIGH = 8'h2F;
  localparam logic [7:0] OFF_STATUS     = 8'h30;
  // status register field positions
  localparam int BIT_CH1_EN    = 7;
  localparam int BIT_CH0_EN    = 6;
  localparam int BIT_CH1_GUARD = 5;
  localparam int BIT_CH0_GUARD = 4;
  localparam int BIT_CH1_IE    = 3;
  localparam int BIT_CH0_IE    = 2;
  localparam int BIT_MAIN_EN   = 0;
  // values after reset
  localparam logic       RST_ENABLE   = 1'b0;
  localparam logic [7:0] RST_RDATA    = 8'h00;
  localparam logic [1:0] RST_SYNC     = 2'b11;
  // request routing codes in the bank byte, bits 1..0
  localparam logic [1:0] SEL_EXT_REQ  = 2'h0;
  localparam logic [1:0] SEL_SER_A    = 2'h1;
  localparam logic [1:0] SEL_SER_B    = 2'h2;
  // byte counter value that ends a transfer on its last decrement
  localparam logic [15:0] CNT_LAST    = 16'h0001;
  localparam int          FIFO_DEPTH  = 32;
  localparam int          DATA_W      = 8;
endpackage

// File: hdl/dmactl_fifo.sv
// dmactl_fifo: synchronous FIFO with valid/ready on both sides
// assumes one clock; in_ready and out_valid are decoded from the registered count cnt_q
`timescale 1ns/1ps
module dmactl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // pointer and fill bookkeeping
  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset, it holds only data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (reset)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// File: hdl/dmactl_top.sv
// dmactl_top: two-channel DMA enables, byte counters and channel 0 request routing
// assumes a one-cycle io_wr / io_rd strobe from the CPU core on clk; nmi_n, ext request
// pins are asynchronous; byte strobes, serial flags and stream come from clk logic
// Function
// - channel 0 source is 20 bits, three bytes
// - bank bits 1..0 pick request source in I/O
// - 16-bit byte counters decrement per byte moved
// - byte counters are not reset
// - channel 1 runs with its enable and main
// - channel 1 enable clears at count zero
// - channel 1 interrupt while disabled and enabled
// - channel 1 enable written only with guard 0
// - setting channel enable also sets main enable
// - channel 0 runs gated, cleared at zero
// - channel 0 guard bit 4; guards read 1
// - channel 0 interrupt only when bit 2 set
// - NMI clears main enable
// - main enable ignores direct writes
// - reset clears enables and interrupt enables
// - routed serial receiver suppresses its interrupt
`timescale 1ns/1ps
module dmactl_top
  import dmactl_pkg::*;
#(
  parameter int WIDTH = dmactl_pkg::DATA_W,
  parameter int DEPTH = dmactl_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [7:0]       io_addr,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata_q,
  input  wire logic             nmi_n,
  input  wire logic             ext_transfer_request_n,
  input  wire logic             ch0_src_is_io,
  input  wire logic             serial_chan_a_rx_full,
  input  wire logic             serial_chan_b_rx_full,
  input  wire logic             ch1_byte_done,
  input  wire logic             ch0_in_valid,
  input  wire logic [WIDTH-1:0] ch0_in_data,
  output logic                  ch0_in_ready,
  output logic                  ch0_out_valid,
  output logic      [WIDTH-1:0] ch0_out_data,
  input  wire logic             ch0_out_ready,
  output logic                  ch0_active_q,
  output logic                  ch1_active_q,
  output logic                  ch0_request_q,
  output logic                  ch0_term_irq_q,
  output logic                  ch1_term_irq_q,
  output logic                  serial_chan_a_rx_irq_block_q,
  output logic                  serial_chan_b_rx_irq_block_q
);
  import dmactl_pkg::*;

  typedef enum logic [2:0] {
    DMACTL_RD_IDLE   = 3'b001,
    DMACTL_RD_REG    = 3'b010,
    DMACTL_RD_UNMAP  = 3'b100
  } dmactl_rd_t;

  // source address and counters: data only, no reset value
  logic [7:0]  src_lo_q, src_lo_d, src_hi_q, src_hi_d, src_bk_q, src_bk_d;
  logic [15:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;
  // control state with reset
  logic        ch0_en_q, ch0_en_d, ch1_en_q, ch1_en_d;
  logic        ch0_ie_q, ch0_ie_d, ch1_ie_q, ch1_ie_d;
  logic        main_en_q, main_en_d;
  logic [2:0]  nmi_s_q, req_s_q;
  logic        nmi_st_q, nmi_st_d, req_st_q, req_st_d;
  logic        nmi_event;
  logic        wr_status, wr_ch0_en, wr_ch1_en;
  logic        ch0_push, ch0_last, ch1_last;
  logic        fifo_in_ready;
  logic        req_sel, req_d, term0_d, term1_d, blk_a_d, blk_b_d;
  logic [7:0]  rdata_d, status_rd;
  dmactl_rd_t  rd_kind;

  // pin synchronisers: three stages, change accepted once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nmi_s_q  <= 3'h7;
      req_s_q  <= 3'h7;
      nmi_st_q <= 1'b1;
      req_st_q <= 1'b1;
    end else begin
      nmi_s_q  <= {nmi_s_q[1:0], nmi_n};
      req_s_q  <= {req_s_q[1:0], ext_transfer_request_n};
      nmi_st_q <= nmi_st_d;
      req_st_q <= req_st_d;
    end
  end

  always_comb begin
    nmi_st_d  = (nmi_s_q[2] == nmi_s_q[1]) ? nmi_s_q[2] : nmi_st_q;
    req_st_d  = (req_s_q[2] == req_s_q[1]) ? req_s_q[2] : req_st_q;
    nmi_event = nmi_st_q && !nmi_st_d; // falling edge of the filtered pin
  end

  // write decode; guard bit must be written 0 for an enable to change
  always_comb begin
    wr_status = io_wr && (io_addr == OFF_STATUS);
    wr_ch1_en = wr_status && !io_wdata[BIT_CH1_GUARD];
    wr_ch0_en = wr_status && !io_wdata[BIT_CH0_GUARD];
  end

  // a channel moves bytes only while both its enable and the main enable are set
  always_comb begin
    ch0_in_ready = fifo_in_ready && ch0_en_q && main_en_q;
    ch0_push     = ch0_in_valid && ch0_in_ready;
    ch0_last     = ch0_push && (cnt0_q == CNT_LAST);
    ch1_last     = ch1_byte_done && ch1_active_q && (cnt1_q == CNT_LAST);
  end

  // source address and byte counters; software write wins over a decrement
  always_comb begin
    src_lo_d = src_lo_q;
    src_hi_d = src_hi_q;
    src_bk_d = src_bk_q;
    cnt0_d   = cnt0_q;
    cnt1_d   = cnt1_q;
    if (ch0_push) begin
      cnt0_d = cnt0_q - 16'h0001;
    end
    // counter 1 moves only on bytes the outside engine reports while active
    if (ch1_byte_done && ch1_active_q) begin
      cnt1_d = cnt1_q - 16'h0001;
    end
    if (io_wr) begin
      case (io_addr)
        OFF_SRC0_LOW:   src_lo_d = io_wdata;
        OFF_SRC0_HIGH:  src_hi_d = io_wdata;
        OFF_SRC0_BANK:  src_bk_d = io_wdata;
        OFF_BCNT0_LOW:  cnt0_d[7:0]  = io_wdata;
        OFF_BCNT0_HIGH: cnt0_d[15:8] = io_wdata;
        OFF_BCNT1_LOW:  cnt1_d[7:0]  = io_wdata;
        OFF_BCNT1_HIGH: cnt1_d[15:8] = io_wdata;
        default: ;
      endcase
    end
  end

  // no reset here: counter contents stay undefined until software loads them
  always_ff @(posedge clk) begin
    src_lo_q <= src_lo_d;
    src_hi_q <= src_hi_d;
    src_bk_q <= src_bk_d;
    cnt0_q   <= cnt0_d;
    cnt1_q   <= cnt1_d;
  end

  // enables: a software write with its guard bit 0 beats termination in the same cycle,
  // nmi beats a restart so the service routine is never entered with DMA live
  always_comb begin
    ch0_en_d  = ch0_last ? 1'b0 : ch0_en_q;
    ch1_en_d  = ch1_last ? 1'b0 : ch1_en_q;
    ch0_ie_d  = ch0_ie_q;
    ch1_ie_d  = ch1_ie_q;
    main_en_d = main_en_q;
    if (wr_ch0_en) begin
      ch0_en_d = io_wdata[BIT_CH0_EN];
    end
    if (wr_ch1_en) begin
      ch1_en_d = io_wdata[BIT_CH1_EN];
    end
    // interrupt enables follow every status write, guarded or not
    if (wr_status) begin
      ch0_ie_d = io_wdata[BIT_CH0_IE];
      ch1_ie_d = io_wdata[BIT_CH1_IE];
    end
    if ((wr_ch0_en && io_wdata[BIT_CH0_EN]) || (wr_ch1_en && io_wdata[BIT_CH1_EN])) begin
      main_en_d = 1'b1;
    end
    if (nmi_event) begin
      main_en_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ch0_en_q  <= RST_ENABLE;
      ch1_en_q  <= RST_ENABLE;
      ch0_ie_q  <= RST_ENABLE;
      ch1_ie_q  <= RST_ENABLE;
      main_en_q <= RST_ENABLE;
    end else begin
      ch0_en_q  <= ch0_en_d;
      ch1_en_q  <= ch1_en_d;
      ch0_ie_q  <= ch0_ie_d;
      ch1_ie_q  <= ch1_ie_d;
      main_en_q <= main_en_d;
    end
  end

  // request routing, interrupt levels and serial interrupt blocking
  // routing reads the registered bank byte; block flags follow its next value
  always_comb begin
    case (src_bk_q[1:0])
      SEL_EXT_REQ: req_sel = !req_st_q;
      SEL_SER_A:   req_sel = serial_chan_a_rx_full;
      SEL_SER_B:   req_sel = serial_chan_b_rx_full;
      default:     req_sel = 1'b0; // reserved code requests nothing
    endcase
    req_d   = ch0_src_is_io && ch0_en_d && main_en_d && req_sel;
    term0_d = !ch0_en_d && ch0_ie_d;
    term1_d = !ch1_en_d && ch1_ie_d;
    blk_a_d = ch0_src_is_io && (src_bk_d[1:0] == SEL_SER_A);
    blk_b_d = ch0_src_is_io && (src_bk_d[1:0] == SEL_SER_B);
  end

  // read path: unmapped offsets answer zero
  // rd_kind tells mapped from unmapped reads for the read checks
  always_comb begin
    status_rd = {ch1_en_q, ch0_en_q, 1'b1, 1'b1, ch1_ie_q, ch0_ie_q, 1'b0, main_en_q};
    rd_kind   = DMACTL_RD_IDLE;
    rdata_d   = io_rdata_q;
    if (io_rd) begin
      rd_kind = DMACTL_RD_REG;
      case (io_addr)
        OFF_SRC0_LOW:   rdata_d = src_lo_q;
        OFF_SRC0_HIGH:  rdata_d = src_hi_q;
        OFF_SRC0_BANK:  rdata_d = src_bk_q;
        OFF_BCNT0_LOW:  rdata_d = cnt0_q[7:0];
        OFF_BCNT0_HIGH: rdata_d = cnt0_q[15:8];
        OFF_BCNT1_LOW:  rdata_d = cnt1_q[7:0];
        OFF_BCNT1_HIGH: rdata_d = cnt1_q[15:8];
        OFF_STATUS:     rdata_d = status_rd;
        default: begin
          rd_kind = DMACTL_RD_UNMAP;
          rdata_d = RST_RDATA;
        end
      endcase
    end
  end

  // outputs registered from next values so they switch with the enables
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_rdata_q                   <= RST_RDATA;
      ch0_active_q                 <= 1'b0;
      ch1_active_q                 <= 1'b0;
      ch0_request_q                <= 1'b0;
      ch0_term_irq_q               <= 1'b0;
      ch1_term_irq_q               <= 1'b0;
      serial_chan_a_rx_irq_block_q <= 1'b0;
      serial_chan_b_rx_irq_block_q <= 1'b0;
    end else begin
      io_rdata_q                   <= rdata_d;
      ch0_active_q                 <= ch0_en_d && main_en_d;
      ch1_active_q                 <= ch1_en_d && main_en_d;
      ch0_request_q                <= req_d;
      ch0_term_irq_q               <= term0_d;
      ch1_term_irq_q               <= term1_d;
      serial_chan_a_rx_irq_block_q <= blk_a_d;
      serial_chan_b_rx_irq_block_q <= blk_b_d;
    end
  end

  // channel 0 data passes through the buffer; its ready stalls the counter
  // write side is gated so a stopped channel cannot fill the buffer
  dmactl_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (ch0_in_valid && ch0_en_q && main_en_q),
    .in_data   (ch0_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (ch0_out_valid),
    .out_data  (ch0_out_data),
    .out_ready (ch0_out_ready)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // enables, guards and main enable
  chk_guard_blocks_ch1: assert property (
    io_wr && io_addr == OFF_STATUS && io_wdata[BIT_CH1_GUARD] && !ch1_last
    |=> ch1_en_q == $past(ch1_en_q)) else $error("guarded ch1 enable changed");
  chk_ch0_set_main: assert property (
    io_wr && io_addr == OFF_STATUS && !io_wdata[BIT_CH0_GUARD] && io_wdata[BIT_CH0_EN]
    && !nmi_event |=> main_en_q && ch0_en_q) else $error("ch0 set did not raise main");
  chk_ch1_term_clear: assert property (
    ch1_last && !wr_ch1_en |=> !ch1_en_q && !ch1_active_q) else $error("ch1 not cleared");
  chk_ch0_term_clear: assert property (
    ch0_last && !wr_ch0_en |=> !ch0_en_q) else $error("ch0 not cleared at zero");
  chk_nmi_clears_main: assert property (
    nmi_event |=> !main_en_q && !ch0_active_q && !ch1_active_q) else $error("nmi kept dma");
  chk_main_no_direct: assert property (
    !main_en_q && !(wr_ch0_en && io_wdata[BIT_CH0_EN]) && !(wr_ch1_en && io_wdata[BIT_CH1_EN])
    |=> !main_en_q) else $error("main enable set directly");
  chk_ch1_irq_level: assert property (
    ch1_term_irq_q == (!ch1_en_q && ch1_ie_q)) else $error("ch1 irq wrong");
  chk_ch0_irq_gate: assert property (
    !ch0_ie_q |-> !ch0_term_irq_q) else $error("ch0 irq without enable");
  chk_guard_reads_one: assert property (
    io_rd && io_addr == OFF_STATUS |=> io_rdata_q[5:4] == 2'b11) else $error("guard bits");
  chk_ch0_count_dec: assert property (
    ch0_push && !(io_wr && (io_addr == OFF_BCNT0_LOW || io_addr == OFF_BCNT0_HIGH))
    |=> cnt0_q == $past(cnt0_q) - 16'h0001) else $error("ch0 count not decremented");
  // routing and serial blocking
  chk_route_serial_a: assert property (
    ch0_src_is_io && src_bk_q[1:0] == SEL_SER_A && !(io_wr && io_addr == OFF_SRC0_BANK)
    |=> serial_chan_a_rx_irq_block_q) else $error("serial a not blocked");
  chk_route_serial_b: assert property (
    ch0_src_is_io && src_bk_q[1:0] == SEL_SER_B && !(io_wr && io_addr == OFF_SRC0_BANK)
    |=> serial_chan_b_rx_irq_block_q) else $error("serial b not blocked");
  chk_req_needs_io: assert property (
    !ch0_src_is_io |=> !ch0_request_q) else $error("request without io source");
  chk_reserved_no_req: assert property (
    src_bk_q[1:0] == 2'h3 |=> !ch0_request_q) else $error("reserved code requested");

  // second channel, counters and remaining gates
  chk_guard_blocks_ch0: assert property (
    io_wr && io_addr == OFF_STATUS && io_wdata[BIT_CH0_GUARD] && !ch0_last
    |=> ch0_en_q == $past(ch0_en_q)) else $error("guarded ch0 enable changed");
  chk_ch1_set_main: assert property (
    io_wr && io_addr == OFF_STATUS && !io_wdata[BIT_CH1_GUARD] && io_wdata[BIT_CH1_EN]
    && !nmi_event |=> main_en_q && ch1_en_q) else $error("ch1 set did not raise main");
  chk_ch1_count_dec: assert property (
    ch1_byte_done && ch1_active_q
    && !(io_wr && (io_addr == OFF_BCNT1_LOW || io_addr == OFF_BCNT1_HIGH))
    |=> cnt1_q == $past(cnt1_q) - 16'h0001) else $error("ch1 count not decremented");
  chk_ch0_in_gate: assert property (
    !(ch0_en_q && main_en_q) |-> !ch0_in_ready) else $error("ch0 accepted while stopped");
  chk_ch1_active_gate: assert property (
    ch1_active_q |-> ch1_en_q && main_en_q) else $error("ch1 active while stopped");
  chk_ch0_irq_level: assert property (
    ch0_term_irq_q == (!ch0_en_q && ch0_ie_q)) else $error("ch0 irq wrong");
  chk_unmapped_zero: assert property (
    rd_kind == DMACTL_RD_UNMAP |=> io_rdata_q == RST_RDATA) else $error("unmapped read not zero");

  cov_ch0_terminates: cover property (ch0_last ##1 ch0_term_irq_q);
  cov_nmi_restart:    cover property (nmi_event ##[1:20] main_en_q);
  cov_fifo_full:      cover property (ch0_in_valid && !fifo_in_ready);
  cov_ch1_terminates: cover property (ch1_last ##1 ch1_term_irq_q);
  cov_route_serial_b: cover property (serial_chan_b_rx_irq_block_q && ch0_request_q);
endmodule

// File: test/dmactl_sink.sv
// dmactl_sink: drain model for the channel 0 fifo output side
// assumes stall is changed by the bench just after a rising edge
`timescale 1ns/1ps
module dmactl_sink (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       stall,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  output logic            out_ready,
  output logic      [7:0] rx_cnt
);
  logic [7:0] mem [0:63];
  // a slow reader is modelled as a long stall
  assign out_ready = !stall;
  // keep every byte taken at a handshake edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_cnt <= 8'h00;
    end else if (out_valid && out_ready) begin
      mem[rx_cnt[5:0]] <= out_data;
      rx_cnt <= rx_cnt + 8'h01;
    end
  end
endmodule

// File: test/dma_channel_control_tb_top.sv
// dma_channel_control_tb_top: directed tests of the dma control block
// assumes inputs move 1 ns after each rising edge, one access per strobe
`timescale 1ns/1ps
module dma_channel_control_tb_top;
  import dmactl_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata_q;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic       nmi_n = 1'b1;
  logic       ext_n = 1'b1;
  logic       src_io = 1'b0;
  logic       ser_a = 1'b0;
  logic       ser_b = 1'b0;
  logic       b_done = 1'b0;
  logic       in_v = 1'b0;
  logic [7:0] in_d = 8'h00;
  logic       in_r, out_v, out_r, act0, act1, req0, irq0, irq1, blk_a, blk_b;
  logic [7:0] out_d, rx_cnt;
  logic       stall = 1'b0;
  int         failures = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  localparam logic [7:0] OFFS [7] = '{8'h20, 8'h21, 8'h22, 8'h26, 8'h27, 8'h2E, 8'h2F};
  localparam logic [7:0] VALS [7] = '{8'hA5, 8'h5A, 8'h05, 8'h34, 8'h12, 8'hC3, 8'h3C};

  dmactl_top i_dut (.clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .nmi_n(nmi_n),
    .ext_transfer_request_n(ext_n), .ch0_src_is_io(src_io),
    .serial_chan_a_rx_full(ser_a), .serial_chan_b_rx_full(ser_b),
    .ch1_byte_done(b_done), .ch0_in_valid(in_v), .ch0_in_data(in_d),
    .ch0_in_ready(in_r), .ch0_out_valid(out_v), .ch0_out_data(out_d),
    .ch0_out_ready(out_r), .ch0_active_q(act0), .ch1_active_q(act1),
    .ch0_request_q(req0), .ch0_term_irq_q(irq0), .ch1_term_irq_q(irq1),
    .serial_chan_a_rx_irq_block_q(blk_a), .serial_chan_b_rx_irq_block_q(blk_b));
  dmactl_sink i_sink (.clk(clk), .reset(reset), .stall(stall), .out_valid(out_v),
    .out_data(out_d), .out_ready(out_r), .rx_cnt(rx_cnt));

  // free-running 100 MHz clock
  always #5 clk = ~clk;
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d values, %0d wrong", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    check(16'(io_rdata_q), 16'(exp));
    cyc(1);
  endtask
  // offer bytes 0,1,..; ready is read mid-cycle, where it equals its edge value
  task automatic push(input int want, output int n);
    logic r;
    n = 0;
    in_v = 1'b1;
    for (int k = 0; k < 40 && n < want; k++) begin
      in_d = n[7:0];
      #4 r = in_r;
      @(posedge clk);
      #1;
      if (r === 1'b1) n++;
    end
    in_v = 1'b0;
  endtask
  task automatic pulse();
    b_done = 1'b1;
    cyc(1);
    b_done = 1'b0;
    cyc(1);
  endtask

  task automatic t_reset();
    rdc(OFF_STATUS, 8'h30);
    check(16'({irq0, irq1, act0, act1, req0}), 16'h0000);
    rdc(8'h23, 8'h00);
    for (int i = 0; i < 7; i++) wr(OFFS[i], VALS[i]);
    for (int i = 0; i < 7; i++) rdc(OFFS[i], VALS[i]);
    $display("test reset and registers done");
  endtask
  task automatic t_guard();
    wr(OFF_STATUS, 8'h70);
    rdc(OFF_STATUS, 8'h30);
    wr(OFF_STATUS, 8'h31);
    rdc(OFF_STATUS, 8'h30);
    wr(OFF_STATUS, 8'h60);
    check(16'(act0), 16'h0001);
    rdc(OFF_STATUS, 8'h71);
    wr(OFF_STATUS, 8'h20);
    check(16'(act0), 16'h0000);
    rdc(OFF_STATUS, 8'h31);
    $display("test guards done");
  endtask
  // fifo fills while the reader stalls, then the last byte ends the count
  task automatic t_stream();
    int n;
    wr(OFF_BCNT0_LOW, 8'h21);
    wr(OFF_BCNT0_HIGH, 8'h00);
    wr(OFF_STATUS, 8'h64);
    stall = 1'b1;
    push(33, n);
    check(16'(n), 16'h0020);
    check(16'({act0, irq0}), 16'h0002);
    stall = 1'b0;
    cyc(40);
    check(16'(rx_cnt), 16'd32);
    check({i_sink.mem[0], i_sink.mem[31]}, 16'h001F);
    check(16'(out_v), 16'h0000);
    push(1, n);
    check(16'({act0, irq0, in_r}), 16'h0002);
    cyc(5);
    check(16'({irq0, rx_cnt}), 16'h0121);
    rdc(OFF_STATUS, 8'h35);
    wr(OFF_STATUS, 8'h30);
    check(16'(irq0), 16'h0000);
    $display("test channel 0 stream done");
  endtask
  task automatic t_ch1();
    wr(OFF_BCNT1_LOW, 8'h03);
    wr(OFF_BCNT1_HIGH, 8'h00);
    wr(OFF_STATUS, 8'h98);
    for (int i = 0; i < 3; i++) begin
      check(16'({act1, irq1}), 16'h0002);
      pulse();
    end
    check(16'({act1, irq1}), 16'h0001);
    rdc(OFF_STATUS, 8'h39);
    $display("test channel 1 count done");
  endtask
  task automatic t_nmi();
    wr(OFF_BCNT1_LOW, 8'h05);
    wr(OFF_STATUS, 8'h98);
    nmi_n = 1'b0;
    cyc(8);
    nmi_n = 1'b1;
    cyc(8);
    check(16'(act1), 16'h0000);
    rdc(OFF_STATUS, 8'hB8);
    wr(OFF_STATUS, 8'hB9);
    rdc(OFF_STATUS, 8'hB8);
    wr(OFF_STATUS, 8'h98);
    check(16'(act1), 16'h0001);
    $display("test nmi done");
  endtask
  // each routing code: first only the other sources, then only its own
  task automatic t_route();
    wr(OFF_BCNT0_LOW, 8'h00);
    wr(OFF_BCNT0_HIGH, 8'h01);
    wr(OFF_STATUS, 8'h60);
    src_io = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_SRC0_BANK, 8'(c));
      ext_n = (c == 0);
      ser_a = (c != 1);
      ser_b = (c != 2);
      cyc(6);
      check(16'({req0, blk_a, blk_b}), 16'({1'b0, c == 1, c == 2}));
      ext_n = (c != 0);
      ser_a = (c == 1);
      ser_b = (c == 2);
      cyc(6);
      check(16'({req0, blk_a, blk_b}), 16'({c != 3, c == 1, c == 2}));
    end
    wr(OFF_SRC0_BANK, 8'h01);
    ser_a = 1'b1;
    src_io = 1'b0;
    cyc(3);
    check(16'({req0, blk_a}), 16'h0000);
    $display("test request routing done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    cyc(1);
    t_reset();
    t_guard();
    t_stream();
    t_ch1();
    t_nmi();
    t_route();
    results();
  end
endmodule
